// [key_route.sv]
// Data key window comparators and converter output routing with Wishbone registers
`timescale 1ns/100ps
`default_nettype none

module key_route #(
  parameter int PIX_W = 10,
  parameter int KEY_W = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Pixel channels for keying
  input wire logic [PIX_W-1:0] green_in,
  input wire logic [PIX_W-1:0] blue_in,
  input wire logic [PIX_W-1:0] red_in,
  input wire logic active_window_in,
  // Video components for the converters
  input wire logic [PIX_W-1:0] luma_in,
  input wire logic [PIX_W-1:0] pb_in,
  input wire logic [PIX_W-1:0] pr_in,
  input wire logic [PIX_W-1:0] chroma_in,
  input wire logic [PIX_W-1:0] composite_out_a_in,
  input wire logic [PIX_W-1:0] composite_out_b_in,
  // Key results
  output logic [2:0] channel_match_out,
  output logic data_key_out,
  // Converter feeds
  output logic [PIX_W-1:0] conv1_data_out,
  output logic [PIX_W-1:0] conv2_data_out,
  output logic [PIX_W-1:0] conv3_data_out,
  output logic [PIX_W-1:0] conv4_data_out,
  output logic [3:0] conv_off_out,
  output logic sync_on_green_out,
  output logic ext_sync_out,
  output logic overlay_table_off_out
);

  // ==========================================================
  // Register state
  logic [KEY_W-1:0] key_upper [key_route_pkg::NUM_CH];
  logic [KEY_W-1:0] key_lower [key_route_pkg::NUM_CH];
  logic [KEY_W-1:0] next_key_upper [key_route_pkg::NUM_CH];
  logic [KEY_W-1:0] next_key_lower [key_route_pkg::NUM_CH];
  logic [7:0] key_control;
  logic [7:0] next_key_control;
  logic [7:0] conv_control;
  logic [7:0] next_conv_control;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;

  logic [5:0] reg_idx;
  logic bus_req;
  logic wr_lane0;

  assign reg_idx = wb_adr_in[7:2];
  // No request is seen while ack is high, so a held request is taken again every other cycle
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_lane0 = bus_req & wb_we_in & wb_sel_in[0];

  // ==========================================================
  // Register writes
  always_comb begin
    next_key_control = key_control;
    next_conv_control = conv_control;
    for (int c = 0; c < key_route_pkg::NUM_CH; c++) begin
      next_key_upper[c] = key_upper[c];
      next_key_lower[c] = key_lower[c];
    end
    if (wr_lane0) begin
      unique case (reg_idx)
        key_route_pkg::IDX_KEY_CONTROL: begin
          next_key_control = wb_dat_in[7:0] & key_route_pkg::KEY_CONTROL_MASK;
        end
        key_route_pkg::IDX_GREEN_UPPER: begin
          next_key_upper[key_route_pkg::CH_GREEN] = wb_dat_in[KEY_W-1:0];
        end
        key_route_pkg::IDX_GREEN_LOWER: begin
          next_key_lower[key_route_pkg::CH_GREEN] = wb_dat_in[KEY_W-1:0];
        end
        key_route_pkg::IDX_BLUE_UPPER: begin
          next_key_upper[key_route_pkg::CH_BLUE] = wb_dat_in[KEY_W-1:0];
        end
        key_route_pkg::IDX_BLUE_LOWER: begin
          next_key_lower[key_route_pkg::CH_BLUE] = wb_dat_in[KEY_W-1:0];
        end
        key_route_pkg::IDX_RED_UPPER: begin
          next_key_upper[key_route_pkg::CH_RED] = wb_dat_in[KEY_W-1:0];
        end
        key_route_pkg::IDX_RED_LOWER: begin
          next_key_lower[key_route_pkg::CH_RED] = wb_dat_in[KEY_W-1:0];
        end
        // [RQ11] reserved bit dropped
        // Bit 3 is never stored, so its value cannot steer anything
        key_route_pkg::IDX_CONV_CONTROL: begin
          next_conv_control = wb_dat_in[7:0] & key_route_pkg::CONV_CONTROL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      key_control <= key_route_pkg::KEY_CONTROL_RESET;
      conv_control <= key_route_pkg::CONV_CONTROL_RESET;
      for (int c = 0; c < key_route_pkg::NUM_CH; c++) begin
        key_upper[c] <= key_route_pkg::KEY_BOUND_RESET;
        key_lower[c] <= key_route_pkg::KEY_BOUND_RESET;
      end
    end else begin
      key_control <= next_key_control;
      conv_control <= next_conv_control;
      for (int c = 0; c < key_route_pkg::NUM_CH; c++) begin
        key_upper[c] <= next_key_upper[c];
        key_lower[c] <= next_key_lower[c];
      end
    end
  end

  // ==========================================================
  // Key comparators
  logic [PIX_W-1:0] chan_pix [key_route_pkg::NUM_CH];
  logic [key_route_pkg::NUM_CH-1:0] chan_ignore;
  logic [key_route_pkg::NUM_CH-1:0] chan_hit;
  logic [2:0] next_match;
  logic next_key;
  logic key_allowed;

  assign chan_pix[key_route_pkg::CH_GREEN] = green_in;
  assign chan_pix[key_route_pkg::CH_BLUE] = blue_in;
  assign chan_pix[key_route_pkg::CH_RED] = red_in;
  assign chan_ignore[key_route_pkg::CH_GREEN] = key_control[key_route_pkg::GREEN_IGNORE_BIT];
  assign chan_ignore[key_route_pkg::CH_BLUE] = key_control[key_route_pkg::BLUE_IGNORE_BIT];
  assign chan_ignore[key_route_pkg::CH_RED] = key_control[key_route_pkg::RED_IGNORE_BIT];

  // [RQ1] [RQ2] [RQ3] window compare
  // Upper bound inclusive, lower bound exclusive, on the top bits only
  for (genvar g = 0; g < key_route_pkg::NUM_CH; g++) begin : g_cmp
    logic [KEY_W-1:0] top_bits;
    assign top_bits = chan_pix[g][PIX_W-1 -: KEY_W];
    assign chan_hit[g] = (top_bits <= key_upper[g]) & (top_bits > key_lower[g]);
  end

  // [RQ10] key extent gate
  assign key_allowed = key_control[key_route_pkg::KEY_EXTENT_BIT] | active_window_in;

  always_comb begin
    next_match = chan_hit;
    // [RQ9] ignored channels pass
    // All channels ignored gives no key rather than a key everywhere
    next_key = key_allowed & (&(chan_hit | chan_ignore)) & ~(&chan_ignore);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      channel_match_out <= 3'h0;
      data_key_out <= 1'b0;
    end else begin
      channel_match_out <= next_match;
      data_key_out <= next_key;
    end
  end

  // ==========================================================
  // Converter routing
  logic [PIX_W-1:0] route1;
  logic [PIX_W-1:0] route2;
  logic [PIX_W-1:0] route3;
  logic [PIX_W-1:0] next_conv1;
  logic [PIX_W-1:0] next_conv2;
  logic [PIX_W-1:0] next_conv3;
  logic [PIX_W-1:0] next_conv4;
  logic [3:0] next_off;
  logic [1:0] route_sel;

  assign route_sel = conv_control[key_route_pkg::ROUTE_LSB +: key_route_pkg::ROUTE_W];

  always_comb begin
    unique case (route_sel)
      // [RQ5] component routing
      key_route_pkg::ROUTE_COMPONENT: begin
        route1 = luma_in;
        route2 = pb_in;
        route3 = pr_in;
      end
      // [RQ6] separate luma chroma
      key_route_pkg::ROUTE_SVIDEO: begin
        route1 = composite_out_a_in;
        route2 = luma_in;
        route3 = chroma_in;
      end
      // [RQ7] [RQ8] RGB routing
      default: begin
        route1 = green_in;
        route2 = blue_in;
        route3 = red_in;
      end
    endcase
  end

  always_comb begin
    // [RQ4] converter disables
    next_off[0] = conv_control[key_route_pkg::FIRST_OFF_BIT];
    next_off[1] = conv_control[key_route_pkg::LUMA_BLUE_OFF_BIT];
    next_off[2] = conv_control[key_route_pkg::CHROMA_RED_OFF_BIT];
    next_off[3] = conv_control[key_route_pkg::COMPOSITE_OFF_BIT];
    // A switched-off converter is fed zero to keep its input quiet
    next_conv1 = next_off[0] ? '0 : route1;
    next_conv2 = next_off[1] ? '0 : route2;
    next_conv3 = next_off[2] ? '0 : route3;
    next_conv4 = next_off[3] ? '0 : composite_out_b_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      conv1_data_out <= '0;
      conv2_data_out <= '0;
      conv3_data_out <= '0;
      conv4_data_out <= '0;
      conv_off_out <= 4'h0;
      sync_on_green_out <= 1'b0;
      ext_sync_out <= 1'b0;
      overlay_table_off_out <= 1'b0;
    end else begin
      conv1_data_out <= next_conv1;
      conv2_data_out <= next_conv2;
      conv3_data_out <= next_conv3;
      conv4_data_out <= next_conv4;
      conv_off_out <= next_off;
      // [RQ8] sync on green
      sync_on_green_out <= (route_sel == key_route_pkg::ROUTE_RGB_SYNC_G);
      // [RQ7] external sync
      ext_sync_out <= (route_sel == key_route_pkg::ROUTE_RGB_EXT_SYNC);
      overlay_table_off_out <= conv_control[key_route_pkg::OVERLAY_OFF_BIT];
    end
  end

  // ==========================================================
  // Wishbone read and acknowledge
  always_comb begin
    next_wb_ack = bus_req;
    next_wb_dat = 32'h0000_0000;
    if (bus_req && !wb_we_in) begin
      unique case (reg_idx)
        key_route_pkg::IDX_KEY_CONTROL: next_wb_dat[7:0] = key_control;
        key_route_pkg::IDX_GREEN_UPPER: begin
          next_wb_dat[KEY_W-1:0] = key_upper[key_route_pkg::CH_GREEN];
        end
        key_route_pkg::IDX_GREEN_LOWER: begin
          next_wb_dat[KEY_W-1:0] = key_lower[key_route_pkg::CH_GREEN];
        end
        key_route_pkg::IDX_BLUE_UPPER: begin
          next_wb_dat[KEY_W-1:0] = key_upper[key_route_pkg::CH_BLUE];
        end
        key_route_pkg::IDX_BLUE_LOWER: begin
          next_wb_dat[KEY_W-1:0] = key_lower[key_route_pkg::CH_BLUE];
        end
        key_route_pkg::IDX_RED_UPPER: begin
          next_wb_dat[KEY_W-1:0] = key_upper[key_route_pkg::CH_RED];
        end
        key_route_pkg::IDX_RED_LOWER: begin
          next_wb_dat[KEY_W-1:0] = key_lower[key_route_pkg::CH_RED];
        end
        key_route_pkg::IDX_CONV_CONTROL: next_wb_dat[7:0] = conv_control;
        // Live key state for software polling
        key_route_pkg::IDX_KEY_STATUS: next_wb_dat[3:0] = {data_key_out, channel_match_out};
        default: next_wb_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= next_wb_ack;
      wb_dat_out <= next_wb_dat;
    end
  end

endmodule

`default_nettype wire

// [key_route_checker.sv]
// Concurrent checks on the key and converter routing ports
`timescale 1ns/100ps
`default_nettype none
module key_route_checker #(
  parameter int PIX_W = 10
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Sources
  input wire logic [PIX_W-1:0] green_in,
  input wire logic [PIX_W-1:0] blue_in,
  input wire logic [PIX_W-1:0] composite_out_b_in,
  // Results
  input wire logic [2:0] channel_match_out,
  input wire logic data_key_out,
  input wire logic [PIX_W-1:0] conv1_data_out,
  input wire logic [PIX_W-1:0] conv2_data_out,
  input wire logic [PIX_W-1:0] conv4_data_out,
  input wire logic [3:0] conv_off_out,
  input wire logic sync_on_green_out,
  input wire logic ext_sync_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence bus_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence ack_once;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  a_ack_one_pulse: assert property (bus_req |=> ack_once)
    else $error("ack is not a single pulse");
  a_idle_data_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_key_needs_match: assert property (data_key_out |-> channel_match_out != 3'h0)
    else $error("key without channel match");
  a_off_forces_zero: assert property ((conv_off_out[0] |-> conv1_data_out == '0) and
    (conv_off_out[3] |-> conv4_data_out == '0))
    else $error("disabled converter carries data");
  a_sync_exclusive: assert property (!(sync_on_green_out && ext_sync_out))
    else $error("both sync flags high");
  a_ext_green_route: assert property ($past(rst_n_in) && ext_sync_out && !conv_off_out[0]
    |-> conv1_data_out == $past(green_in))
    else $error("converter one not green");
  a_sog_blue_route: assert property ($past(rst_n_in) && sync_on_green_out &&
    !conv_off_out[1] |-> conv2_data_out == $past(blue_in))
    else $error("converter two not blue");
  a_comp_b_route: assert property ($past(rst_n_in) && !conv_off_out[3]
    |-> conv4_data_out == $past(composite_out_b_in))
    else $error("converter four not composite b");
endmodule
bind key_route key_route_checker #(.PIX_W(PIX_W)) u_chk (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .green_in(green_in), .blue_in(blue_in),
  .composite_out_b_in(composite_out_b_in), .channel_match_out(channel_match_out),
  .data_key_out(data_key_out), .conv1_data_out(conv1_data_out),
  .conv2_data_out(conv2_data_out), .conv4_data_out(conv4_data_out),
  .conv_off_out(conv_off_out), .sync_on_green_out(sync_on_green_out),
  .ext_sync_out(ext_sync_out));
`default_nettype wire

// [key_route_pkg.sv]
// Constants for the data key comparators and converter routing block
// ==========================================================
// Function
// [RQ1] Green key match when upper 8 bits are at most upper bound and above lower.
// [RQ2] Blue key match when upper 8 bits are at most upper bound and above lower.
// [RQ3] Red key match when upper 8 bits are at most upper bound and above lower.
// [RQ4] Control bits 7 to 4 each switch off one converter; bit 7 is composite.
// [RQ5] Routing mode 00 sends luma, Pb, Pr, composite b to converters one to four.
// [RQ6] Routing mode 01 sends composite a, luma, chroma, composite b.
// [RQ7] Routing mode 10 sends green, blue, red, composite b with external sync.
// [RQ8] Routing mode 11 sends green, blue, red, composite b with sync on green.
// [RQ9] A channel with its ignore bit high takes no part in the data key; the code gives no key when all three are ignored.
// [RQ10] Extent select low keys only in active window; high keys the whole frame.
// [RQ11] Software writes zero to reserved control bit 3; device ignores it.
package key_route_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_KEY_CONTROL = 6'h09;
  localparam logic [5:0] IDX_GREEN_UPPER = 6'h0A;
  localparam logic [5:0] IDX_GREEN_LOWER = 6'h0B;
  localparam logic [5:0] IDX_BLUE_UPPER = 6'h0C;
  localparam logic [5:0] IDX_BLUE_LOWER = 6'h0D;
  localparam logic [5:0] IDX_RED_UPPER = 6'h0E;
  localparam logic [5:0] IDX_RED_LOWER = 6'h0F;
  localparam logic [5:0] IDX_CONV_CONTROL = 6'h10;
  localparam logic [5:0] IDX_KEY_STATUS = 6'h12;

  // ==========================================================
  // Key control fields
  localparam int KEY_EXTENT_BIT = 5;
  localparam int GREEN_IGNORE_BIT = 4;
  localparam int BLUE_IGNORE_BIT = 3;
  localparam int RED_IGNORE_BIT = 2;
  localparam logic [7:0] KEY_CONTROL_MASK = 8'h3C;

  // ==========================================================
  // Converter control fields
  localparam int COMPOSITE_OFF_BIT = 7;
  localparam int CHROMA_RED_OFF_BIT = 6;
  localparam int LUMA_BLUE_OFF_BIT = 5;
  localparam int FIRST_OFF_BIT = 4;
  localparam int OVERLAY_OFF_BIT = 2;
  localparam int ROUTE_LSB = 0;
  localparam int ROUTE_W = 2;
  localparam logic [7:0] CONV_CONTROL_MASK = 8'hF7;

  // Routing modes
  localparam logic [1:0] ROUTE_COMPONENT = 2'h0;
  localparam logic [1:0] ROUTE_SVIDEO = 2'h1;
  localparam logic [1:0] ROUTE_RGB_EXT_SYNC = 2'h2;
  localparam logic [1:0] ROUTE_RGB_SYNC_G = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] KEY_BOUND_RESET = 8'h00;
  localparam logic [7:0] KEY_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONV_CONTROL_RESET = 8'h00;

  // Channel order in the comparator arrays
  localparam int CH_GREEN = 0;
  localparam int CH_BLUE = 1;
  localparam int CH_RED = 2;
  localparam int NUM_CH = 3;

endpackage

// [pix_src.sv]
// Upstream component source model feeding the converter inputs
`timescale 1ns/100ps
`default_nettype none
module pix_src (
  // Clock
  input wire logic clk_in,
  // Component samples
  output logic [9:0] y_out,
  output logic [9:0] pb_out,
  output logic [9:0] pr_out,
  output logic [9:0] c_out,
  output logic [9:0] ca_out,
  output logic [9:0] cb_out
);
  logic [9:0] n = 10'h000;
  // New values every cycle, so a stale or swapped route shows
  always @(posedge clk_in) n <= n + 10'h001;
  assign y_out = n;
  assign pb_out = n ^ 10'h155;
  assign pr_out = n ^ 10'h2AA;
  assign c_out = n ^ 10'h0F0;
  assign ca_out = n ^ 10'h30F;
  assign cb_out = n ^ 10'h3C3;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the data key and converter routing block
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] kc, gv, bv, rv; logic a; logic [2:0] m; logic k;} row_s;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, aw = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, dat, rd;
  logic [9:0] g = 10'h000, b = 10'h000, r = 10'h000;
  logic [9:0] y, pb, pr, ch, ca, cb, c1, c2, c3, c4, src [6];
  logic ack, key, sog, ext, olut;
  logic [2:0] mt;
  logic [3:0] sel = 4'hF, coff, off;
  logic [1:0] m;
  int fails = 0, n_compared = 0;
  // Bounds: 40 exclusive, 80 inclusive on every channel
  row_s rows [7] = '{'{8'h00, 8'h41, 8'h80, 8'h41, 1'b1, 3'h7, 1'b1},
    '{8'h00, 8'h40, 8'h80, 8'h81, 1'b1, 3'h2, 1'b0},
    '{8'h00, 8'h80, 8'h41, 8'h80, 1'b0, 3'h7, 1'b0},
    '{8'h20, 8'h80, 8'h41, 8'h80, 1'b0, 3'h7, 1'b1},
    '{8'h14, 8'h40, 8'h41, 8'h81, 1'b1, 3'h2, 1'b1},
    '{8'h1C, 8'h41, 8'h41, 8'h41, 1'b1, 3'h7, 1'b0},
    '{8'h08, 8'h41, 8'h00, 8'h80, 1'b1, 3'h5, 1'b1}};
  always #4 clk = ~clk;
  key_route u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dat),
    .wb_ack_out(ack), .green_in(g), .blue_in(b), .red_in(r), .active_window_in(aw),
    .luma_in(y), .pb_in(pb), .pr_in(pr), .chroma_in(ch), .composite_out_a_in(ca),
    .composite_out_b_in(cb), .channel_match_out(mt), .data_key_out(key),
    .conv1_data_out(c1), .conv2_data_out(c2), .conv3_data_out(c3), .conv4_data_out(c4),
    .conv_off_out(coff), .sync_on_green_out(sog), .ext_sync_out(ext),
    .overlay_table_off_out(olut));
  pix_src u_src (.clk_in(clk), .y_out(y), .pb_out(pb), .pr_out(pr), .c_out(ch),
    .ca_out(ca), .cb_out(cb));
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, v);
    n_compared++;
    if (v !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, v);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      k++;
      if (k > 20) begin
        fails++;
        report_and_stop;
      end
      @(posedge clk);
    end
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Sources are captured mid-cycle, the result one edge later
  task automatic pix(input logic [7:0] gv, bv, rv, input logic a);
    @(posedge clk);
    g <= {gv, 2'b11};
    b <= {bv, 2'b01};
    r <= {rv, 2'b10};
    aw <= a;
    @(negedge clk);
    src = '{y, pb, pr, ch, ca, cb};
    @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, key_route_pkg::IDX_CONV_CONTROL, 8'h00);
    chk("conv reset", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, key_route_pkg::IDX_GREEN_UPPER + 6'(i), i[0] ? 8'h40 : 8'h80);
    end
    bus(1'b0, key_route_pkg::IDX_RED_LOWER, 8'h00);
    chk("red lower", 32'h40, rd);
    bus(1'b1, 6'h3F, 8'hFF);
    bus(1'b0, 6'h3F, 8'h00);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i]) begin
      bus(1'b1, key_route_pkg::IDX_KEY_CONTROL, rows[i].kc);
      pix(rows[i].gv, rows[i].bv, rows[i].rv, rows[i].a);
      chk("match", rows[i].m, mt);
      chk("key", rows[i].k, key);
    end
    // Pixel inputs still hold the last row, so the live status is steady
    bus(1'b0, key_route_pkg::IDX_KEY_STATUS, 8'h00);
    chk("key status", {rows[6].k, rows[6].m}, rd);
    bus(1'b0, key_route_pkg::IDX_KEY_CONTROL, 8'h00);
    chk("key control", rows[6].kc, rd);
    for (int i = 0; i < 8; i++) begin
      m = 2'(i);
      off = i > 3 ? 4'h1 << m : 4'h0;
      bus(1'b1, key_route_pkg::IDX_CONV_CONTROL, {off, 2'b00, m});
      pix(8'h41, 8'h42, 8'h43, 1'b1);
      chk("conv1", off[0] ? 10'h0 : m == 0 ? src[0] : m == 1 ? src[4] : g, c1);
      chk("conv2", off[1] ? 10'h0 : m == 0 ? src[1] : m == 1 ? src[0] : b, c2);
      chk("conv3", off[2] ? 10'h0 : m == 0 ? src[2] : m == 1 ? src[3] : r, c3);
      chk("conv4", off[3] ? 10'h0 : src[5], c4);
      chk("conv off", off, coff);
      chk("sync", {m == 2'h2, m == 2'h3}, {ext, sog});
    end
    bus(1'b1, key_route_pkg::IDX_CONV_CONTROL, 8'h07);
    bus(1'b0, key_route_pkg::IDX_CONV_CONTROL, 8'h00);
    chk("conv ctrl", 32'h07, rd);
    pix(8'h41, 8'h41, 8'h41, 1'b1);
    chk("overlay off", 32'h1, olut);
    // Reset in mid-run clears routing
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, key_route_pkg::IDX_CONV_CONTROL, 8'h00);
    chk("conv after reset", 32'h0, rd);
    chk("sync after reset", 32'h0, {ext, sog});
    report_and_stop;
  end
endmodule
`default_nettype wire
